// *** bench/bsc_host_model.sv ***
// Host bus model driving the burst SRAM cycle control inputs
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"

module bsc_host_model (
    input  wire logic                   clk,
    output logic                        primary_chip_enable_n,
    output logic                        depth_select_high,
    output logic                        depth_select_low_n,
    output logic                        sleep_request,
    output logic                        processor_addr_strobe_n,
    output logic                        controller_addr_strobe_n,
    output logic                        burst_advance_n,
    output logic                        global_write_n,
    output logic                        lane_write_enable_n,
    output logic                        lane_a_select_n,
    output logic                        lane_b_select_n,
    output logic                        lane_c_select_n,
    output logic                        lane_d_select_n,
    output logic                        output_enable_n,
    output logic                        burst_order_sel,
    output logic [`BSC_ADDR_W-1:0]      addr_in,
    output logic [31:0]                 data_in,
    output logic [3:0]                  parity_in
);

    initial
    begin
        {primary_chip_enable_n, depth_select_high, depth_select_low_n} = 3'h4;
        {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
        {burst_advance_n, global_write_n, lane_write_enable_n} = 3'h7;
        {lane_d_select_n, lane_c_select_n} = 2'h3;
        {lane_b_select_n, lane_a_select_n} = 2'h3;
        {output_enable_n, burst_order_sel, sleep_request} = 3'h6;
        addr_in = '0;
        {parity_in, data_in} = 36'h0;
    end

    // One bus cycle: ce={primary_n,depth_high,depth_low_n},
    // st={proc_n,ctrl_n,adv_n}, we={global_n,lane_en_n,lanes d..a}
    task automatic cyc(input logic [2:0] ce, input logic [2:0] st,
                       input logic [5:0] we, input logic [18:0] a,
                       input logic [35:0] d);
        logic wr;
        wr = !we[5] || (!we[4] && we[3:0] != 4'hF);
        @(posedge clk);
        {primary_chip_enable_n, depth_select_high, depth_select_low_n} <= ce;
        {processor_addr_strobe_n, controller_addr_strobe_n} <= st[2:1];
        burst_advance_n <= st[0];
        {global_write_n, lane_write_enable_n} <= we[5:4];
        {lane_d_select_n, lane_c_select_n} <= we[3:2];
        {lane_b_select_n, lane_a_select_n} <= we[1:0];
        addr_in <= a;
        // Pins are turned off in the same step that write data appears on them
        if (wr)
            output_enable_n <= 1'b1;
        // Released data lines never keep a stale value
        {parity_in, data_in} <= wr ? d : ~{parity_in, data_in};
        #1;
    endtask : cyc

    // Asynchronous controls, changed between clock edges
    task automatic set_ctl(input logic oe_n, input logic order,
                           input logic slp);
        output_enable_n <= oe_n;
        burst_order_sel <= order;
        sleep_request <= slp;
        #1;
    endtask : set_ctl

endmodule : bsc_host_model

`default_nettype wire

// *** bench/bsc_sram_ctrl_tb.sv ***
// Self-checking testbench for the burst SRAM cycle control block
`timescale 1ns/1ps
`default_nettype none

module bsc_sram_ctrl_tb;
    import bsc_pkg::*;

    localparam logic [2:0] EN = 3'h2;

    logic        clk;
    logic        rstn;
    logic        primary_chip_enable_n, depth_select_high, depth_select_low_n;
    logic        sleep_request, processor_addr_strobe_n;
    logic        controller_addr_strobe_n, burst_advance_n, global_write_n;
    logic        lane_write_enable_n, lane_a_select_n, lane_b_select_n;
    logic        lane_c_select_n, lane_d_select_n, output_enable_n;
    logic        burst_order_sel;
    logic [18:0] addr_in;
    logic [31:0] data_in;
    logic [31:0] data_out;
    logic [3:0]  parity_in;
    logic [3:0]  parity_out;
    logic        data_oe, parity_oe, write_dropped;
    int          n_fail;
    int          checked;

    bsc_host_model i_host (
        .clk, .primary_chip_enable_n, .depth_select_high,
        .depth_select_low_n, .sleep_request, .processor_addr_strobe_n,
        .controller_addr_strobe_n, .burst_advance_n, .global_write_n,
        .lane_write_enable_n, .lane_a_select_n, .lane_b_select_n,
        .lane_c_select_n, .lane_d_select_n, .output_enable_n,
        .burst_order_sel, .addr_in, .data_in, .parity_in
    );

    bsc_sram_ctrl i_dut (
        .clk, .rstn, .primary_chip_enable_n, .depth_select_high,
        .depth_select_low_n, .sleep_request, .processor_addr_strobe_n,
        .controller_addr_strobe_n, .burst_advance_n, .global_write_n,
        .lane_write_enable_n, .lane_a_select_n, .lane_b_select_n,
        .lane_c_select_n, .lane_d_select_n, .output_enable_n,
        .burst_order_sel, .addr_in, .data_in, .parity_in, .data_out,
        .data_oe, .parity_out, .parity_oe, .write_dropped
    );

    always #4 clk = ~clk;

    function automatic logic [35:0] w(input logic [18:0] x);
        return {x[3:0], 13'h0AB5, x};
    endfunction : w

    task automatic chk(input string what, input logic [35:0] seen,
                       input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // Write a burst from an aligned base, then read it back from base+1
    task automatic t_burst(input logic order, input logic [18:0] base);
        logic [1:0] k2;
        i_host.set_ctl(1'b1, order, 1'b0);
        i_host.cyc(EN, 3'h5, 6'h1F, base, w(base));
        for (int k = 1; k < 4; k++)
            i_host.cyc(EN, 3'h6, 6'h1F, '0, w(base + 19'(k)));
        i_host.cyc(EN, 3'h3, 6'h3F, base + 19'h1, '0);
        i_host.set_ctl(1'b0, order, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            i_host.cyc(EN, (k == 3) ? 3'h7 : 3'h6, 6'h3F, '0, '0);
            k2 = order ? (2'h1 ^ k[1:0]) : (2'h1 + k[1:0]);
            chk("burst", {parity_out, data_out}, w(base + {17'h0, k2}));
            chk("drive", {34'h0, data_oe, parity_oe}, 36'h3);
        end
    endtask : t_burst

    // Clear one lane at a time, then show idle lane inputs do not write
    task automatic t_lanes(input logic [18:0] a);
        logic [35:0] e;
        e = 36'hF_FFFF_FFFF;
        i_host.cyc(EN, 3'h5, 6'h1F, a, e);
        for (int i = 0; i < 4; i++)
        begin
            i_host.cyc(EN, 3'h5, {2'h2, ~(4'h1 << i)}, a, 36'h0);
            e = e & ~((36'h1 << (32 + i)) | (36'hFF << (8 * i)));
            i_host.cyc(EN, 3'h5, 6'h3F, a, '0);
            i_host.cyc(EN, 3'h7, 6'h3F, '0, '0);
            chk("lanes", {parity_out, data_out}, e);
        end
        i_host.cyc(EN, 3'h3, 6'h1F, a, '0);
        i_host.cyc(EN, 3'h5, 6'h30, a, 36'h0);
        i_host.cyc(EN, 3'h5, 6'h2F, a, 36'h0);
        i_host.cyc(EN, 3'h7, 6'h3F, '0, '0);
        chk("nowrite", {parity_out, data_out}, e);
    endtask : t_lanes

    // Processor start ignores write inputs; write lands on the suspend
    task automatic t_suspend(input logic [18:0] a);
        i_host.cyc(EN, 3'h3, 6'h1F, a, 36'h0);
        i_host.cyc(EN, 3'h7, 6'h1F, '0, 36'h9_1234_5678);
        chk("pstart", {parity_out, data_out}, w(a));
        chk("oe_off", {34'h0, data_oe, parity_oe}, 36'h0);
        i_host.set_ctl(1'b0, 1'b1, 1'b0);
        i_host.cyc(EN, 3'h7, 6'h3F, '0, '0);
        chk("wmask", {34'h0, data_oe, parity_oe}, 36'h0);
        i_host.cyc(EN, 3'h7, 6'h3F, '0, '0);
        chk("rewrite", {parity_out, data_out}, 36'h9_1234_5678);
        chk("rd_oe", {34'h0, data_oe, parity_oe}, 36'h3);
        i_host.set_ctl(1'b1, 1'b1, 1'b0);
        chk("async", {34'h0, data_oe, parity_oe}, 36'h0);
        i_host.set_ctl(1'b0, 1'b1, 1'b1);
        chk("sleep", {34'h0, data_oe, parity_oe}, 36'h0);
        i_host.cyc(EN, 3'h7, 6'h3F, '0, '0);
        chk("sleep_edge", {34'h0, data_oe, parity_oe}, 36'h0);
        i_host.set_ctl(1'b0, 1'b1, 1'b0);
        i_host.cyc(EN, 3'h7, 6'h3F, '0, '0);
        chk("sleep_end", {34'h0, data_oe, parity_oe}, 36'h0);
    endtask : t_suspend

    // Primary off at a controller start, or either depth enable off at a strobe start, turns an open read into a deselect
    task automatic t_desel(input logic [18:0] a);
        logic [2:0] ce_t [4] = '{3'h6, 3'h0, 3'h3, 3'h3};
        logic [2:0] st_t [4] = '{3'h5, 3'h3, 3'h3, 3'h5};
        for (int i = 0; i < 4; i++)
        begin
            i_host.cyc(EN, 3'h3, 6'h3F, a, '0);
            i_host.cyc(ce_t[i], st_t[i], 6'h3F, a, '0);
            chk("sel_oe", {34'h0, data_oe, parity_oe}, 36'h3);
            i_host.cyc(EN, 3'h6, 6'h3F, '0, '0);
            chk("desel", {34'h0, data_oe, parity_oe}, 36'h0);
        end
    endtask : t_desel

    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        n_fail = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_burst(1'b1, 19'h100);
        t_burst(1'b0, 19'h200);
        t_lanes(19'h300);
        t_suspend(19'h100);
        t_desel(19'h200);
        chk("dropped", {35'h0, write_dropped}, 36'h0);
        stop_test();
    end

    // The sequence needs well under 200 cycles
    initial
    begin
        #20000;
        n_fail++;
        stop_test();
    end

endmodule : bsc_sram_ctrl_tb

`default_nettype wire

// *** design/bsc_pkg.sv ***
// Types shared by the burst SRAM cycle control block
`include "bsc_regs.svh"

package bsc_pkg;

    typedef enum logic [1:0] {
        BSC_DESEL,
        BSC_SLEEP,
        BSC_READ,
        BSC_WRITE
    } bsc_cycle_t;

    typedef struct packed {
        logic [`BSC_ADDR_W-1:0] addr;
        logic [`BSC_LANES-1:0]  mask;
        logic [`BSC_WORD_W-1:0] word;
    } bsc_wr_entry_t;

endpackage : bsc_pkg

// *** design/bsc_regs.svh ***
// Constants for the burst SRAM cycle control block
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

// Address width of the 512K-word array
`define BSC_ADDR_W 19
// Byte lanes, bits per lane (8 data + 1 parity)
`define BSC_LANES 4
`define BSC_BYTE_W 8
`define BSC_LANE_W 9
`define BSC_WORD_W 36
`define BSC_ALL_LANES 4'hF
`define BSC_NO_LANES 4'h0
// Write buffer depth in entries
`define BSC_FIFO_DEPTH 32
// Burst counter
`define BSC_CNT_W 2
`define BSC_CNT_ZERO 2'h0
`define BSC_CNT_STEP 2'h1

`endif

// *** design/bsc_sram_ctrl.sv ***
// Cycle decode, burst counter, byte writes and data drive of the burst SRAM
// Summary of operation
// - Primary enable off with controller strobe, or depth enable off at a strobe start: deselect
// - Sleep input high forces sleep, pins tristated, whatever else happens
// - All enables on and processor strobe low: burst read at external address
// - Controller strobe start with write condition true: write external address
// - Controller strobe start, write condition false: read external address
// - Continue with advance low and no write: read next counter address
// - Continue with advance low and write: write next counter address
// - Advance high: hold counter and read the current address
// - Advance high with write: write again to the current address
// - Write condition: global write low, or lane enable low with a lane low
// - Lane enable low: each low lane select writes its byte and parity
// - Writes only on a controller start or in a later cycle of any active burst
// - Output enable acts combinationally on the drivers, never registered
// - Output enable is masked during write cycles
// - Read cycle drives data and parity while output enable is low
// - Pin drive depends only on current cycle, output enable level and sleep input
// - Two-bit counter from low address bits; order input picks sequence
// - Interleaved XORs start with beat count; linear adds modulo four
// - Low global write overrides lane inputs and writes every lane
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"

module bsc_wr_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = `BSC_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] store [DEPTH];
    logic [PW:0]  wr_ptr;
    logic [PW:0]  rd_ptr;
    logic [PW:0]  next_wr_ptr;
    logic [PW:0]  next_rd_ptr;

    initial
    begin
        if (DEPTH < 2 || (1 << PW) != DEPTH)
            $error("bsc_wr_fifo: DEPTH must be a power of two >= 2");
    end

    assign in_ready  = !((wr_ptr[PW] != rd_ptr[PW]) &&
                         (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = store[rd_ptr[PW-1:0]];

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (in_valid && in_ready)
            next_wr_ptr = wr_ptr + (PW+1)'(1);
        if (out_valid && out_ready)
            next_rd_ptr = rd_ptr + (PW+1)'(1);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage carries no reset; only the pointers say what is valid
    always_ff @(posedge clk)
    begin
        if (in_valid && in_ready)
            store[wr_ptr[PW-1:0]] <= in_data;
    end
endmodule : bsc_wr_fifo

module bsc_sram_ctrl
    import bsc_pkg::*;
#(
    parameter int ADDR_W     = `BSC_ADDR_W,
    parameter int FIFO_DEPTH = `BSC_FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              primary_chip_enable_n,
    input  wire logic              depth_select_high,
    input  wire logic              depth_select_low_n,
    input  wire logic              sleep_request,
    input  wire logic              processor_addr_strobe_n,
    input  wire logic              controller_addr_strobe_n,
    input  wire logic              burst_advance_n,
    input  wire logic              global_write_n,
    input  wire logic              lane_write_enable_n,
    input  wire logic              lane_a_select_n,
    input  wire logic              lane_b_select_n,
    input  wire logic              lane_c_select_n,
    input  wire logic              lane_d_select_n,
    input  wire logic              output_enable_n,
    input  wire logic              burst_order_sel,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [31:0]       data_in,
    input  wire logic [3:0]        parity_in,
    output logic [31:0]            data_out,
    output logic                   data_oe,
    output logic [3:0]             parity_out,
    output logic                   parity_oe,
    output logic                   write_dropped
);
    initial
    begin
        if (ADDR_W < `BSC_CNT_W + 1 || ADDR_W > `BSC_ADDR_W)
            $error("bsc_sram_ctrl: ADDR_W out of range");
    end

    logic [`BSC_WORD_W-1:0] core [1 << ADDR_W];

    bsc_cycle_t             cyc;
    bsc_cycle_t             next_cyc;
    logic [ADDR_W-1:0]      base;
    logic [ADDR_W-1:0]      next_base;
    logic [`BSC_CNT_W-1:0]  cnt;
    logic [`BSC_CNT_W-1:0]  next_cnt;
    logic                   active;
    logic                   next_active;
    logic                   order;
    logic                   next_order;
    logic [ADDR_W-1:0]      acc_addr;
    logic                   do_write;
    logic                   do_read;
    logic                   ce_ok;
    logic                   wr_cond;
    logic [`BSC_LANES-1:0]  lanes_n;
    logic [`BSC_LANES-1:0]  lane_mask;
    logic [`BSC_WORD_W-1:0] wr_word;
    logic [`BSC_WORD_W-1:0] rd_word;
    logic [`BSC_WORD_W-1:0] next_rd_word;
    logic [`BSC_WORD_W-1:0] core_word;
    logic                   dropped;
    logic                   next_dropped;
    bsc_wr_entry_t          push_entry;
    bsc_wr_entry_t          head;
    logic                   push_ready;
    logic                   head_valid;
    logic                   drain;
    logic                   fwd_hit;

    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0]     b,
        input logic [`BSC_CNT_W-1:0] c,
        input logic                  ilv
    );
        logic [`BSC_CNT_W-1:0] low;
        low = ilv ? (b[`BSC_CNT_W-1:0] ^ c)
                  : (b[`BSC_CNT_W-1:0] + c);
        return {b[ADDR_W-1:`BSC_CNT_W], low};
    endfunction : burst_addr

    assign ce_ok   = !primary_chip_enable_n && depth_select_high &&
                     !depth_select_low_n;
    assign lanes_n = {lane_d_select_n, lane_c_select_n,
                      lane_b_select_n, lane_a_select_n};
    assign wr_cond = !global_write_n ||
                     (!lane_write_enable_n && !(&lanes_n));
    assign lane_mask = !global_write_n ? `BSC_ALL_LANES
                     : (!lane_write_enable_n ? ~lanes_n
                                             : `BSC_NO_LANES);

    always_comb
    begin
        next_cyc    = BSC_DESEL;
        next_base   = base;
        next_cnt    = cnt;
        next_active = active;
        next_order  = order;
        acc_addr    = burst_addr(base, cnt, order);
        do_write    = 1'b0;
        do_read     = 1'b0;
        if (sleep_request)
        begin
            next_cyc    = BSC_SLEEP;
            next_active = 1'b0;
        end
        else if (!primary_chip_enable_n && !processor_addr_strobe_n)
        begin
            next_active = ce_ok;
            if (ce_ok)
            begin
                next_base  = addr_in;
                next_cnt   = `BSC_CNT_ZERO;
                next_order = burst_order_sel;
                acc_addr   = addr_in;
                do_read    = 1'b1;
                next_cyc   = BSC_READ;
            end
        end
        else if (!controller_addr_strobe_n)
        begin
            next_active = ce_ok;
            if (ce_ok)
            begin
                next_base  = addr_in;
                next_cnt   = `BSC_CNT_ZERO;
                next_order = burst_order_sel;
                acc_addr   = addr_in;
                do_write   = wr_cond;
                do_read    = !wr_cond;
                next_cyc   = wr_cond ? BSC_WRITE : BSC_READ;
            end
        end
        else if (active)
        begin
            if (!burst_advance_n)
                next_cnt = cnt + `BSC_CNT_STEP;
            acc_addr = burst_addr(base, next_cnt, order);
            do_write = wr_cond;
            do_read  = !wr_cond;
            next_cyc = wr_cond ? BSC_WRITE : BSC_READ;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cyc    <= BSC_DESEL;
            base   <= '0;
            cnt    <= `BSC_CNT_ZERO;
            active <= 1'b0;
            order  <= 1'b1;
        end
        else
        begin
            cyc    <= next_cyc;
            base   <= next_base;
            cnt    <= next_cnt;
            active <= next_active;
            order  <= next_order;
        end
    end

    // Writes are queued and retired one per cycle; the core stands still in
    // sleep, but no write is queued there either, so at most one entry waits
    assign push_entry.addr = `BSC_ADDR_W'(acc_addr);
    assign push_entry.mask = lane_mask;
    assign push_entry.word = wr_word;
    assign drain   = head_valid && !sleep_request;
    assign fwd_hit = drain && (head.addr == `BSC_ADDR_W'(acc_addr));
    assign core_word = core[acc_addr];

    bsc_wr_fifo #(
        .W     ($bits(bsc_wr_entry_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (do_write),
        .in_ready  (push_ready),
        .in_data   (push_entry),
        .out_valid (head_valid),
        .out_ready (drain),
        .out_data  (head)
    );

    genvar g;
    generate
        for (g = 0; g < `BSC_LANES; g++)
        begin : g_lane
            localparam int LO = g * `BSC_LANE_W;
            assign wr_word[LO +: `BSC_LANE_W] =
                {parity_in[g], data_in[g*`BSC_BYTE_W +: `BSC_BYTE_W]};
            // Read of a word retiring this edge sees the retiring bytes
            assign next_rd_word[LO +: `BSC_LANE_W] =
                (fwd_hit && head.mask[g]) ? head.word[LO +: `BSC_LANE_W]
                                          : core_word[LO +: `BSC_LANE_W];
            assign data_out[g*`BSC_BYTE_W +: `BSC_BYTE_W] =
                rd_word[LO +: `BSC_BYTE_W];
            assign parity_out[g] = rd_word[LO + `BSC_BYTE_W];
            always_ff @(posedge clk)
            begin
                if (drain && head.mask[g])
                    core[ADDR_W'(head.addr)][LO +: `BSC_LANE_W] <=
                        head.word[LO +: `BSC_LANE_W];
            end
        end
    endgenerate

    assign next_dropped = dropped || (do_write && !push_ready);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_word <= '0;
            dropped <= 1'b0;
        end
        else
        begin
            if (do_read)
                rd_word <= next_rd_word;
            dropped <= next_dropped;
        end
    end

    assign write_dropped = dropped;
    // Output enable is never clocked; sleep gates the drivers directly
    assign data_oe   = (cyc == BSC_READ) && !output_enable_n &&
                       !sleep_request;
    assign parity_oe = data_oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_sleep_tristate: assert property (
        sleep_request |-> !data_oe ##1 cyc == BSC_SLEEP)
        else $error("drivers on or no sleep while sleep requested");
    a_desel_cycle: assert property (
        (!sleep_request && !controller_addr_strobe_n &&
         primary_chip_enable_n) |=> (cyc == BSC_DESEL && !active))
        else $error("deselect not taken");
    a_processor_addr_strobe_n_read: assert property (
        (!sleep_request && ce_ok && !processor_addr_strobe_n &&
         !global_write_n) |=> (cyc == BSC_READ && cnt == 2'h0))
        else $error("processor start did not read");
    a_controller_addr_strobe_n_write: assert property (
        (!sleep_request && ce_ok && processor_addr_strobe_n &&
         !controller_addr_strobe_n && wr_cond) |=> cyc == BSC_WRITE)
        else $error("controller start did not write");
    a_controller_addr_strobe_n_read: assert property (
        (!sleep_request && ce_ok && processor_addr_strobe_n &&
         !controller_addr_strobe_n && !wr_cond) |=> cyc == BSC_READ)
        else $error("controller start did not read");
    a_burst_step: assert property (
        (!sleep_request && active && controller_addr_strobe_n &&
         (processor_addr_strobe_n || primary_chip_enable_n) &&
         !burst_advance_n) |=> cnt == $past(cnt) + 2'h1)
        else $error("burst counter did not step");
    a_suspend_hold: assert property (
        (!sleep_request && active && controller_addr_strobe_n &&
         (processor_addr_strobe_n || primary_chip_enable_n) &&
         burst_advance_n) |=> $stable(cnt) && $stable(base))
        else $error("suspended burst moved");
    a_write_masks_oe: assert property (
        (cyc == BSC_WRITE) |-> !data_oe && !parity_oe)
        else $error("drivers on during write");
    a_global_lanes: assert property (
        !global_write_n |-> (lane_mask == 4'hF && wr_cond))
        else $error("global write missed a lane");
    a_no_cond_write: assert property (
        (global_write_n && (lane_write_enable_n || &lanes_n)) |->
        !do_write)
        else $error("write without write condition");
    a_write_queued: assert property (
        (do_write && !sleep_request && !head_valid) |=> head_valid)
        else $error("write not queued");
endmodule : bsc_sram_ctrl

`default_nettype wire
